// ### ppcm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ppcm_checker (
   input wire logic clock, // clock
   input wire logic rst_n, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic [15:0] pullupOff, // pull-up disables
   input wire logic clockOutPinOe, // clock-out enable
   input wire logic [3:0] portcPadIn, // pad levels
   input wire logic [3:0] portcGpioIn, // to gpio
   input wire logic [3:0] timerIn, // to timer
   input wire logic [3:0] spiIn // to spi
);
   import ppcm_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // bus answers and holds
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer moved");
   property p_rd_hi;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
   // unused pull-up positions never reach pads
   property p_pu_rsv;
      (pullupOff & ~PULLUP_MASK) == 16'h0000;
   endproperty
   a_pu_rsv: assert property (p_pu_rsv) else $error("reserved pull-up bit set");
   property p_oe_rst;
      !$past(rst_n) |-> !clockOutPinOe;
   endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("clock-out driven after reset");
   // pad level goes to one user only
   property p_route;
      ((portcGpioIn | timerIn | spiIn) & ~portcPadIn) == 4'h0
      && ((portcGpioIn & timerIn) | (portcGpioIn & spiIn) | (timerIn & spiIn)) == 4'h0;
   endproperty
   a_route: assert property (p_route) else $error("pad input misrouted");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_oe: cover property (clockOutPinOe);
endmodule
`default_nettype wire

// ### ppcm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppcm_far_model (
   input wire logic clock, // clock
   input wire logic [31:0] rnd, // random word
   output logic [31:0] clkSources, // clock candidates
   output logic [35:0] side // pad and peripheral levels
);
   logic [31:0] q;
   // fresh levels each cycle so a stale value never passes
   always_ff @(posedge clock) begin
      q <= rnd;
   end
   assign clkSources = {q[15:0], q[31:16]};
   assign side = {q, q[3:0] ^ q[31:28]};
endmodule
`default_nettype wire

// ### ppcm_pad_pullup_clock_out_mux.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ppcm_pad_pullup_clock_out_mux (
   input wire logic clock, // system clock
   input wire logic rst_n, // synchronous reset, low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic [15:0] pullupOff, // per-bit pull-up disable to pads
   input wire logic [ppcm_pkg::NUM_CLK_SRC-1:0] clkSources, // candidate clocks
   output logic clockOutPin, // clock-out pin level
   output logic clockOutPinOe, // clock-out pin drive enable
   input wire logic [3:0] portbAddrHi, // address bits a23..a20
   input wire logic rawOscClock, // raw oscillator clock
   input wire logic secondarySysClock, // secondary system clock
   input wire logic systemClock, // system clock copy
   input wire logic prescalerClock, // prescaler reference clock
   input wire logic [3:0] portbGpioOut, // port b gpio data 7..4
   output logic [3:0] portbPinOut, // port b pins 7..4 levels
   input wire logic [3:0] portcGpioOut, // port c gpio data
   input wire logic [3:0] timerOut, // timer outputs
   input wire logic [3:0] timerOutputEnable, // timer output enables
   input wire logic [3:0] spiOut, // spi outputs
   input wire logic [3:0] spiOe, // spi output enables
   input wire logic [3:0] portcPadIn, // port c pad inputs
   output ppcm_pkg::ppcm_pad_t [3:0] portcPad, // port c pad drive
   output logic [3:0] portcGpioIn, // pad level to gpio
   output logic [3:0] timerIn, // pad level to timer/decoder
   output logic [3:0] spiIn // pad level to spi
);
   import ppcm_pkg::*;

   // ----------------------------------------
   // overview
   // ----------------------------------------
   // four 16-bit control words sit behind the register bus:
   //   pull-up disable, one bit per functional pin group
   //   clock-out select, source code, tristate bit and port b alternates
   //   port c peripheral select, one bit per pin
   //   port control, the gpio peripheral enables and port c direction
   // every word is one aligned 32-bit slot; upper half reads zero
   // reserved positions are masked on the way in, so reads need no mask
   // only byte lanes 0 and 1 carry state; lanes 2 and 3 are ignored
   //
   // the pad side is pure combinational decode of the stored words;
   // a write therefore shows at the pads right after the edge that
   // stores it, with no further pipeline stage in between
   //
   // hazards a user should know:
   //   clock-out source change is not glitch free; the source vector is
   //   indexed straight, so a runt pulse may appear on the pin when the
   //   code moves while both clocks are mid-cycle
   //   port b alternate clocks reach the pins the same way
   //   port c direction under spi or timer control is the peripheral's
   //   own business; this block only forwards its enables
   //
   // trade-off: a single outstanding write and a single outstanding read
   // keep the slave tiny; throughput is irrelevant for setup registers
   //
   // bus timing in short:
   //   write address and data may arrive in either order
   //   the response rises one edge after both are held
   //   the register changes at that same edge
   //   read data rises at the same edge that takes the address
   //   unmapped addresses answer slverr and change nothing

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0] pullupDisable_q;
   logic [15:0] clockOutSelect_q;
   logic [15:0] portcPeripheralSelect_q;
   logic [15:0] portControl_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bValid_q;
   logic bErr_q;
   logic rValid_q;
   logic [31:0] rData_q;
   logic rErr_q;
   logic doWrite;
   logic [15:0] wMerged;
   logic wHit;
   logic [15:0] rdWord;
   logic rdHit;

   // ----------------------------------------
   // axi4-lite write path
   // ----------------------------------------
   // address and data are latched independently, so either may come first
   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bErr_q ? RESP_SLVERR : RESP_OKAY;

   // address capture
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_q <= 1'b0;
      end
   end

   // data capture
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld_q <= 1'b0;
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bValid_q <= 1'b0;
         bErr_q <= 1'b0;
      end else if (doWrite) begin
         bValid_q <= 1'b1;
         bErr_q <= !wHit;
      end else if (s_axi_bready) begin
         bValid_q <= 1'b0;
      end
   end

   // byte-lane merge against the addressed register
   always_comb begin
      wHit = 1'b1;
      unique case (awAddr_q)
         ADDR_PULLUP_DISABLE: wMerged = pullupDisable_q;
         ADDR_CLOCK_OUT_SELECT: wMerged = clockOutSelect_q;
         ADDR_PORTC_PERIPHERAL_SELECT: wMerged = portcPeripheralSelect_q;
         ADDR_PORT_CONTROL: wMerged = portControl_q;
         default: begin
            wMerged = 16'h0000;
            wHit = 1'b0;
         end
      endcase
      if (wStrb_q[0]) begin
         wMerged[7:0] = wData_q[7:0];
      end
      if (wStrb_q[1]) begin
         wMerged[15:8] = wData_q[15:8];
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // masks keep reserved bits at zero whatever is written
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pullupDisable_q <= PULLUP_RESET;
      end else if (doWrite && awAddr_q == ADDR_PULLUP_DISABLE) begin
         pullupDisable_q <= wMerged & PULLUP_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clockOutSelect_q <= CLKOSR_RESET;
      end else if (doWrite && awAddr_q == ADDR_CLOCK_OUT_SELECT) begin
         clockOutSelect_q <= wMerged & CLKOSR_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         portcPeripheralSelect_q <= GPS_RESET;
      end else if (doWrite && awAddr_q == ADDR_PORTC_PERIPHERAL_SELECT) begin
         portcPeripheralSelect_q <= wMerged & GPS_MASK;
      end
   end

   // port b enables [3:0], port c direction [7:4], port c enables [11:8]
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         portControl_q <= PORTCTL_RESET;
      end else if (doWrite && awAddr_q == ADDR_PORT_CONTROL) begin
         portControl_q <= wMerged & PORTCTL_MASK;
      end
   end

   // ----------------------------------------
   // axi4-lite read path
   // ----------------------------------------
   assign s_axi_arready = !rValid_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rErr_q ? RESP_SLVERR : RESP_OKAY;

   always_comb begin
      rdHit = 1'b1;
      unique case (s_axi_araddr)
         ADDR_PULLUP_DISABLE: rdWord = pullupDisable_q;
         ADDR_CLOCK_OUT_SELECT: rdWord = clockOutSelect_q;
         ADDR_PORTC_PERIPHERAL_SELECT: rdWord = portcPeripheralSelect_q;
         ADDR_PORT_CONTROL: rdWord = portControl_q;
         default: begin
            rdWord = 16'h0000;
            rdHit = 1'b0;
         end
      endcase
   end

   // read data held until rready; one read in flight
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rErr_q <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_q <= 1'b1;
         rData_q <= {16'h0000, rdWord};
         rErr_q <= !rdHit;
      end else if (s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // pad muxing
   // ----------------------------------------
   // pull-up groups map one bit per group straight to the pads
   // bit 14: fault a3 input
   // bit 13: can receive pin
   // bit 12: memory-mode strap pin
   // bit 11: external reset pin
   // bit 10: both external interrupt pins
   // bit 9: boot-mode strap pin
   // bit 8: the four fault b inputs
   // bit 7: fault a inputs 0 to 2
   // bit 5: external bus read and write strobes
   // bit 3: jtag reset, mode select and data in
   // a one turns the pull-ups of the whole group off, a zero leaves them on
   // reserved bits are zero by the write mask, so the pads never see them
   assign pullupOff = pullupDisable_q;

   // clock-out; codes index the source vector directly so the clock-out pin is
   // glitch-prone on source change, acceptable for a test/debug output
   assign clockOutPin = clkSources[clockOutSelect_q[CLK_SRC_LSB +: CLK_SRC_W]];
   assign clockOutPinOe = !clockOutSelect_q[CLK_TRISTATE_BIT];

   // port b upper pins: gpio first, then address or clock
   // index 3 is pin 7 and index 0 is pin 4; the alternate bit of each
   // pin only matters while its peripheral enable is set, because gpio
   // mode always wins over the address/clock choice
   // pin 7: address a23 or raw oscillator clock
   // pin 6: address a22 or secondary system clock
   // pin 5: address a21 or system clock
   // pin 4: address a20 or prescaler reference clock
   logic [3:0] pbAltClock;
   assign pbAltClock = {rawOscClock, secondarySysClock, systemClock, prescalerClock};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PB_ALT; gi++) begin : gPortB
         logic altSel;
         logic perOut;
         assign altSel = clockOutSelect_q[ALT_SEL_LSB + gi];
         assign perOut = altSel ? pbAltClock[gi] : portbAddrHi[gi];
         assign portbPinOut[gi] = portControl_q[PORTB_PER_LSB + gi] ?
            perOut : portbGpioOut[gi];
      end
      // each port c pin decoded alone
      // enable 0: gpio, direction register sets the drive
      // enable 1, select 0: timer/decoder, timer enable sets the drive
      // enable 1, select 1: spi, spi enable sets the drive
      // input routing hands the pad level to the selected user only,
      // so an unselected peripheral never sees a live pin
      for (gi = 0; gi < NUM_PC; gi++) begin : gPortC
         logic perEn;
         logic spiSel;
         assign perEn = portControl_q[PORTC_PER_LSB + gi];
         assign spiSel = portcPeripheralSelect_q[gi];
         always_comb begin
            if (!perEn) begin
               portcPad[gi].out = portcGpioOut[gi];
               portcPad[gi].oe = portControl_q[PORTC_DIR_LSB + gi];
            end else if (!spiSel) begin
               portcPad[gi].out = timerOut[gi];
               portcPad[gi].oe = timerOutputEnable[gi];
            end else begin
               portcPad[gi].out = spiOut[gi];
               portcPad[gi].oe = spiOe[gi];
            end
         end
         // decoder always listens while the pin is timer/decoder
         assign portcGpioIn[gi] = perEn ? 1'b0 : portcPadIn[gi];
         assign timerIn[gi] = (perEn && !spiSel) ? portcPadIn[gi] : 1'b0;
         assign spiIn[gi] = (perEn && spiSel) ? portcPadIn[gi] : 1'b0;
      end
   endgenerate

endmodule

`default_nettype wire

// ### ppcm_pkg.sv
package ppcm_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   // word indices 8, 9, 11 and 16 on a byte-addressed bus, four bytes per word
   localparam logic [7:0] ADDR_PULLUP_DISABLE = 8'h20;
   localparam logic [7:0] ADDR_CLOCK_OUT_SELECT = 8'h24;
   localparam logic [7:0] ADDR_PORTC_PERIPHERAL_SELECT = 8'h2C;
   localparam logic [7:0] ADDR_PORT_CONTROL = 8'h40;

   // ----------------------------------------
   // writable masks and reset values
   // ----------------------------------------
   localparam logic [15:0] PULLUP_MASK = 16'h7FA8;
   localparam logic [15:0] PULLUP_RESET = 16'h0000;
   localparam logic [15:0] CLKOSR_MASK = 16'h03FF;
   localparam logic [15:0] CLKOSR_RESET = 16'h0020;
   localparam logic [15:0] GPS_MASK = 16'h000F;
   localparam logic [15:0] GPS_RESET = 16'h0000;
   localparam logic [15:0] PORTCTL_MASK = 16'hFFFF;
   localparam logic [15:0] PORTCTL_RESET = 16'h0F00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CLK_SRC_LSB = 0;
   localparam int CLK_SRC_W = 5;
   localparam int CLK_TRISTATE_BIT = 5;
   localparam int ALT_SEL_LSB = 6;
   localparam int PORTB_PER_LSB = 0;
   localparam int PORTC_DIR_LSB = 4;
   localparam int PORTC_PER_LSB = 8;
   localparam int NUM_PC = 4;
   localparam int NUM_PB_ALT = 4;

   // clock-out source codes
   localparam logic [4:0] SRC_SYSTEM = 5'h00;
   localparam logic [4:0] SRC_OSC = 5'h07;
   localparam logic [4:0] SRC_PLL = 5'h08;
   localparam logic [4:0] SRC_ADC_A = 5'h10;
   localparam logic [4:0] SRC_ADC_B = 5'h11;
   localparam int NUM_CLK_SRC = 32;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // pad control for one port C pin
   typedef struct packed {
      logic out;
      logic oe;
   } ppcm_pad_t;

endpackage

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ppcm_pkg::*;
   logic clock = 0, rst_n = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, clockOutPin, clockOutPinOe;
   logic rawOscClock, secondarySysClock, systemClock, prescalerClock;
   logic [31:0] s_axi_wdata = 0, rnd = 0, seed = 86844, s_axi_rdata, clkSources;
   logic [35:0] side;
   logic [3:0] s_axi_wstrb = 0, portbAddrHi, portbGpioOut, portbPinOut, portcGpioOut;
   logic [3:0] timerOut, timerOutputEnable, spiOut, spiOe, portcPadIn, portcGpioIn;
   logic [3:0] timerIn, spiIn;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] pullupOff;
   logic [15:0] mdl [4];
   ppcm_pad_t [3:0] portcPad;
   int bad_count = 0, num_checks = 0;
   logic [7:0] adr [5] = '{ADDR_PULLUP_DISABLE, ADDR_CLOCK_OUT_SELECT,
      ADDR_PORTC_PERIPHERAL_SELECT, ADDR_PORT_CONTROL, 8'h30};
   logic [15:0] msk [4] = '{PULLUP_MASK, CLKOSR_MASK, GPS_MASK, PORTCTL_MASK};
   assign {portbAddrHi, rawOscClock, secondarySysClock, systemClock, prescalerClock,
      portbGpioOut, portcGpioOut, timerOut, timerOutputEnable, spiOut, spiOe, portcPadIn} = side;
   ppcm_pad_pullup_clock_out_mux dut (.*);
   ppcm_far_model far (.clock, .rnd, .clkSources, .side);
   // clock and random source
   initial forever #4 clock = ~clock;
   function automatic logic [31:0] xs(logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   always @(posedge clock) begin
      seed <= xs(seed);
      rnd <= xs(seed);
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rst();
      @(posedge clock);
      rst_n <= 0;
      repeat (5) @(posedge clock);
      rst_n <= 1;
      mdl = '{PULLUP_RESET, CLKOSR_RESET, GPS_RESET, PORTCTL_RESET};
   endtask
   // master holds each item until taken, ready until the answer
   task automatic wr(int i, logic [31:0] d, logic [3:0] s);
      int n;
      @(posedge clock);
      s_axi_awaddr <= adr[i];
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid && n < 20);
      s_axi_bready <= 0;
      chk("bresp", {s_axi_bvalid, i < 4 ? RESP_OKAY : RESP_SLVERR}, {1'h1, s_axi_bresp});
      if (i < 4) mdl[i] = msk[i] & {s[1] ? d[15:8] : mdl[i][15:8], s[0] ? d[7:0] : mdl[i][7:0]};
   endtask
   task automatic rd(int i);
      int n;
      @(posedge clock);
      s_axi_araddr <= adr[i];
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid && n < 20);
      s_axi_rready <= 0;
      chk("rdata", {s_axi_rvalid, i < 4 ? mdl[i] : 16'h0000}, {1'h1, s_axi_rdata[15:0]});
      chk("rresp", i < 4 ? RESP_OKAY : RESP_SLVERR, s_axi_rresp);
   endtask
   // pad muxes against the register model
   task automatic pads();
      logic [3:0] pb, alt, gi, ti, si;
      logic per, sel, oe, po;
      @(negedge clock);
      alt = {rawOscClock, secondarySysClock, systemClock, prescalerClock};
      chk("pullup", mdl[0], pullupOff);
      chk("clkoe", !mdl[1][5], clockOutPinOe);
      if (!mdl[1][5]) chk("clock_out_pin", clkSources[mdl[1][4:0]], clockOutPin);
      for (int k = 0; k < 4; k++) begin
         per = mdl[3][8+k];
         sel = mdl[2][k];
         pb[k] = !mdl[3][k] ? portbGpioOut[k] : mdl[1][6+k] ? alt[k] : portbAddrHi[k];
         oe = !per ? mdl[3][4+k] : !sel ? timerOutputEnable[k] : spiOe[k];
         po = !per ? portcGpioOut[k] : !sel ? timerOut[k] : spiOut[k];
         gi[k] = !per & portcPadIn[k];
         ti[k] = per & !sel & portcPadIn[k];
         si[k] = per & sel & portcPadIn[k];
         chk("padoe", oe, portcPad[k].oe);
         if (oe) chk("padout", po, portcPad[k].out);
      end
      chk("portb", pb, portbPinOut);
      chk("pcin", {gi, ti, si}, {portcGpioIn, timerIn, spiIn});
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // reset values, every clock-out code, random traffic, second reset
   initial begin
      rst();
      for (int i = 0; i < 5; i++) rd(i);
      pads();
      $display("reset values done");
      for (int c = 0; c < 32; c++) begin
         wr(1, {rnd[31:10], 1'h0, c[4:0]}, 4'h3);
         pads();
      end
      $display("clock codes done");
      for (int j = 0; j < 60; j++) begin
         wr(int'(rnd[2:0]) % 5, rnd, rnd[31:28]);
         rd(int'(rnd[6:4]) % 5);
         pads();
      end
      $display("random traffic done");
      rst();
      for (int i = 0; i < 4; i++) rd(i);
      pads();
      $display("second reset done");
      final_report();
   end
   // watchdog
   initial begin
      repeat (5000) @(posedge clock);
      bad_count++;
      final_report();
   end
endmodule
bind ppcm_pad_pullup_clock_out_mux ppcm_checker chk_i (.*);
`default_nettype wire
